/* File: conv_model.sv */
// Converter sequencer model driving the status inputs
`timescale 1ns/10ps
`default_nettype none
module conv_model
  import conv_status_pkg::*;
(
  input wire logic pclk,
  output conv_in_s conv_in
);
  // Idle levels, applied by the bench before reset ends
  task automatic idle();
    conv_in <= '0;
  endtask : idle
  task automatic seq(input logic b);
    @(posedge pclk);
    conv_in.busy <= b;
  endtask : seq
  task automatic touch(input logic p, input logic c);
    @(posedge pclk);
    conv_in.pen_touch <= p;
    conv_in.contact_lost <= c;
  endtask : touch
  task automatic ovr();
    @(posedge pclk);
    conv_in.overrun <= 1'b1;
    @(posedge pclk);
    conv_in.overrun <= 1'b0;
  endtask : ovr
  // Result valid only with done, scrambled after
  task automatic done(input logic [11:0] res);
    @(posedge pclk);
    conv_in.conv_done <= 1'b1;
    conv_in.result <= res;
    @(posedge pclk);
    conv_in.conv_done <= 1'b0;
    conv_in.result <= ~res;
  endtask : done
endmodule : conv_model
`default_nettype wire

/* File: conv_status.sv */
// Converter interface status, compare and event flag logic with APB slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module conv_status
  import conv_status_pkg::*;
#(
  parameter int RESULT_WIDTH = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_s apb_req,
  output apb_rsp_s apb_rsp,
  input wire conv_in_s conv_in,
  output logic irq
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  if (RESULT_WIDTH != THR_WIDTH)
  begin : g_width_check
    $error("RESULT_WIDTH must equal threshold width");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic enabled;
    logic touch_en;
    logic compare_en;
    logic [31:0] mode;
    logic [31:0] threshold;
    logic [11:0] last_result;
    logic data_ready;
    logic overrun;
    logic busy_d;
    logic [31:0] prev_status;
    logic [31:0] pending;
    logic [31:0] mask;
    logic [31:0] rdata;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [31:0] live;
  logic wr_en;
  logic rd_en;
  logic above;
  logic below;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_en = apb_req.psel & ~apb_req.pwrite & ~apb_req.penable;

  // ----------------------------------------------------------------------
  // Window compare against twelve bit thresholds
  // ----------------------------------------------------------------------
  assign above = cur.last_result >
    cur.threshold[THR_UPPER_LSB +: THR_WIDTH];
  assign below = cur.last_result <
    cur.threshold[THR_LOWER_LSB +: THR_WIDTH];

  // ----------------------------------------------------------------------
  // Live status word
  // ----------------------------------------------------------------------
  always_comb
  begin
    live = RESET_WORD;
    live[ST_ENABLE] = cur.enabled;
    live[ST_ABOVE_HIGH] = cur.compare_en & above;
    live[ST_BELOW_LOW] = cur.compare_en & below;
    live[ST_COMPARE_ELSE] = cur.compare_en & ~above & ~below;
    live[ST_BUSY] = conv_in.busy;
    live[ST_READY] = ~conv_in.busy;
    live[ST_CONTACT_LOST] = cur.touch_en & conv_in.contact_lost;
    live[ST_PEN_TOUCH] = cur.touch_en & conv_in.pen_touch;
    live[ST_OVERRUN] = cur.overrun;
    live[ST_DATA_READY] = cur.data_ready;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] rise;
    logic [31:0] set_ev;
    rise = live & ~cur.prev_status;
    set_ev = rise & EVENT_BITS;
    set_ev[ST_DATA_READY] = conv_in.conv_done;
    next_cur = cur;
    next_cur.prev_status = live;
    next_cur.busy_d = conv_in.busy;
    if (conv_in.conv_done)
    begin
      next_cur.last_result = conv_in.result[THR_WIDTH-1:0];
      next_cur.data_ready = 1'b1;
    end
    // New sequence restarts overrun tracking
    if (conv_in.busy & ~cur.busy_d)
      next_cur.overrun = 1'b0;
    if (conv_in.overrun)
      next_cur.overrun = 1'b1;
    next_cur.rdata = RESET_WORD;
    if (rd_en)
    begin
      if (hit(apb_req.paddr, OFF_MODE))
        next_cur.rdata = cur.mode;
      else if (hit(apb_req.paddr, OFF_THRESHOLD))
        next_cur.rdata = cur.threshold;
      else if (hit(apb_req.paddr, OFF_LIVE_STATUS))
        next_cur.rdata = live;
      else if (hit(apb_req.paddr, OFF_PENDING_EVENTS))
        next_cur.rdata = cur.pending;
      else if (hit(apb_req.paddr, OFF_IRQ_MASK))
        next_cur.rdata = cur.mask;
      else if (hit(apb_req.paddr, OFF_LAST_RESULT))
        next_cur.rdata = {20'h0, cur.last_result};
    end
    if (wr_en)
    begin
      if (hit(apb_req.paddr, OFF_CONTROL))
      begin
        if (apb_req.pwdata[CMD_BLOCK_ON])
          next_cur.enabled = 1'b1;
        if (apb_req.pwdata[CMD_BLOCK_OFF])
          next_cur.enabled = 1'b0;
      end
      if (hit(apb_req.paddr, OFF_MODE))
      begin
        next_cur.mode = apb_req.pwdata;
        next_cur.touch_en = apb_req.pwdata[MODE_TOUCH_DETECT];
        next_cur.compare_en = apb_req.pwdata[MODE_COMPARE];
      end
      if (hit(apb_req.paddr, OFF_THRESHOLD))
        next_cur.threshold = apb_req.pwdata & 32'h0fff_0fff;
      if (hit(apb_req.paddr, OFF_EVENT_CLEAR))
        next_cur.pending = cur.pending & ~apb_req.pwdata;
      if (hit(apb_req.paddr, OFF_IRQ_ENABLE_SET))
        next_cur.mask = cur.mask | (apb_req.pwdata & EVENT_BITS);
      if (hit(apb_req.paddr, OFF_IRQ_ENABLE_CLEAR))
        next_cur.mask = cur.mask & ~apb_req.pwdata;
    end
    // Set wins over a simultaneous clear
    next_cur.pending = next_cur.pending | set_ev;
    if (wr_en && hit(apb_req.paddr, OFF_CONTROL) &&
        apb_req.pwdata[CMD_SOFT_RESET])
    begin
      next_cur = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign apb_rsp.prdata = cur.rdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = 1'b0;
  assign irq = |(cur.pending & cur.mask);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic soft_wr;
  assign soft_wr = wr_en && hit(apb_req.paddr, OFF_CONTROL)
    && apb_req.pwdata[CMD_SOFT_RESET];

  sequence s_clear_write;
    wr_en && apb_req.paddr == OFF_EVENT_CLEAR;
  endsequence

  sequence s_done_event;
    conv_in.conv_done && !soft_wr;
  endsequence

  sequence s_overrun_masked;
    conv_in.overrun && !live[ST_OVERRUN] && cur.mask[ST_OVERRUN] && !wr_en;
  endsequence

  a_enable_follows_on: assert property (
    wr_en && apb_req.paddr == OFF_CONTROL && apb_req.pwdata[CMD_BLOCK_ON]
    && !apb_req.pwdata[CMD_BLOCK_OFF] && !soft_wr
    |=> live[ST_ENABLE])
    else $error("enable bit did not set");

  a_enable_follows_off: assert property (
    wr_en && apb_req.paddr == OFF_CONTROL && apb_req.pwdata[CMD_BLOCK_OFF]
    |=> !live[ST_ENABLE])
    else $error("enable bit did not clear");

  a_compare_window: assert property (
    $onehot0({live[ST_COMPARE_ELSE], live[ST_ABOVE_HIGH],
      live[ST_BELOW_LOW]}) && (cur.compare_en ==
      (live[ST_COMPARE_ELSE] | live[ST_ABOVE_HIGH] | live[ST_BELOW_LOW])))
    else $error("compare flags inconsistent");

  a_else_inside: assert property (
    cur.compare_en
    && cur.last_result >= cur.threshold[THR_LOWER_LSB +: THR_WIDTH]
    && cur.last_result <= cur.threshold[THR_UPPER_LSB +: THR_WIDTH]
    |-> live[ST_COMPARE_ELSE])
    else $error("compare else flag missing");

  a_above_high_val: assert property (
    live[ST_ABOVE_HIGH]
    |-> cur.last_result > cur.threshold[THR_UPPER_LSB +: THR_WIDTH])
    else $error("above flag without exceeding");

  a_below_low_val: assert property (
    live[ST_BELOW_LOW]
    |-> cur.last_result < cur.threshold[THR_LOWER_LSB +: THR_WIDTH])
    else $error("below flag without falling under");

  a_compare_off: assert property (
    !cur.compare_en |-> !live[ST_COMPARE_ELSE] && !live[ST_ABOVE_HIGH]
    && !live[ST_BELOW_LOW])
    else $error("compare flag while compare off");

  a_busy_ready: assert property (
    live[ST_READY] != live[ST_BUSY] && live[ST_BUSY] == conv_in.busy)
    else $error("busy/ready mismatch");

  a_touch_gated: assert property (
    !cur.touch_en |-> !live[ST_PEN_TOUCH] && !live[ST_CONTACT_LOST])
    else $error("contact flag while detection off");

  a_pen_follows: assert property (
    cur.touch_en && conv_in.pen_touch |-> live[ST_PEN_TOUCH])
    else $error("pen contact not reported");

  a_loss_follows: assert property (
    cur.touch_en && conv_in.contact_lost |-> live[ST_CONTACT_LOST])
    else $error("contact loss not reported");

  a_overrun_held: assert property (
    conv_in.overrun && !soft_wr |=> live[ST_OVERRUN])
    else $error("overrun not recorded");

  a_overrun_restart: assert property (
    conv_in.busy && !cur.busy_d && !conv_in.overrun && !soft_wr
    |=> !live[ST_OVERRUN])
    else $error("overrun kept across new sequence");

  a_ready_sticky: assert property (
    s_done_event |=> live[ST_DATA_READY] && cur.pending[ST_DATA_READY])
    else $error("data ready not set");

  a_ready_held: assert property (
    live[ST_DATA_READY] && !soft_wr |=> live[ST_DATA_READY])
    else $error("data ready lost without reset");

  a_soft_reset: assert property (
    soft_wr |=> !live[ST_DATA_READY] && cur.mask == 32'h0)
    else $error("soft reset left state behind");

  a_rise_pends: assert property (
    $rose(live[ST_BUSY]) && !soft_wr |=> cur.pending[ST_BUSY])
    else $error("rising edge not pended");

  a_pend_holds: assert property (
    cur.pending[ST_BUSY] && !soft_wr
    && !(wr_en && apb_req.paddr == OFF_EVENT_CLEAR && apb_req.pwdata[ST_BUSY])
    |=> cur.pending[ST_BUSY])
    else $error("pending bit dropped without clear");

  a_pend_events_only: assert property (
    (cur.pending & ~EVENT_BITS) == 32'h0)
    else $error("pending bit outside event set");

  a_clear_works: assert property (
    s_clear_write ##0 (apb_req.pwdata[ST_READY]
      && live[ST_READY] == cur.prev_status[ST_READY])
    |=> !cur.pending[ST_READY])
    else $error("pending bit not cleared");

  a_mask_set: assert property (
    wr_en && apb_req.paddr == OFF_IRQ_ENABLE_SET && apb_req.pwdata[ST_OVERRUN]
    |=> cur.mask[ST_OVERRUN])
    else $error("mask not set");

  a_mask_clear: assert property (
    wr_en && apb_req.paddr == OFF_IRQ_ENABLE_CLEAR
    && apb_req.pwdata[ST_DATA_READY] |=> !cur.mask[ST_DATA_READY])
    else $error("mask not cleared");

  a_mask_holds: assert property (
    !wr_en |=> $stable(cur.mask))
    else $error("mask changed without a write");

  a_mask_events_only: assert property (
    (cur.mask & ~EVENT_BITS) == 32'h0)
    else $error("mask bit outside event set");

  a_irq_request: assert property (
    s_overrun_masked ##1 !wr_en |=> irq)
    else $error("masked event raised no irq");

  a_irq_masked: assert property (
    cur.mask == 32'h0 |-> !irq)
    else $error("irq while all sources masked");

  a_rdata_idle: assert property (
    !apb_req.psel |=> apb_rsp.prdata == 32'h0)
    else $error("read data outside a read");

  a_bus_answer: assert property (
    apb_rsp.pready && !apb_rsp.pslverr)
    else $error("bus answer not zero wait");

endmodule : conv_status

`default_nettype wire

/* File: conv_status_pkg.sv */
// Package: register map, status bit layout and bus carrier types
package conv_status_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_THRESHOLD = 8'h10;
  localparam logic [7:0] OFF_LIVE_STATUS = 8'h14;
  localparam logic [7:0] OFF_PENDING_EVENTS = 8'h18;
  localparam logic [7:0] OFF_EVENT_CLEAR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h20;
  localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_LAST_RESULT = 8'h2c;

  // ----------------------------------------------------------------------
  // Control command bits
  // ----------------------------------------------------------------------
  localparam int CMD_SOFT_RESET = 0;
  localparam int CMD_BLOCK_ON = 8;
  localparam int CMD_BLOCK_OFF = 9;

  // ----------------------------------------------------------------------
  // Mode bits
  // ----------------------------------------------------------------------
  localparam int MODE_TOUCH_DETECT = 4;
  localparam int MODE_COMPARE = 5;

  // ----------------------------------------------------------------------
  // Threshold field positions
  // ----------------------------------------------------------------------
  localparam int THR_LOWER_LSB = 0;
  localparam int THR_UPPER_LSB = 16;
  localparam int THR_WIDTH = 12;

  // ----------------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------------
  localparam int ST_DATA_READY = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_PEN_TOUCH = 4;
  localparam int ST_CONTACT_LOST = 5;
  localparam int ST_READY = 8;
  localparam int ST_BUSY = 9;
  localparam int ST_BELOW_LOW = 12;
  localparam int ST_ABOVE_HIGH = 13;
  localparam int ST_COMPARE_ELSE = 14;
  localparam int ST_ENABLE = 24;

  // Event bits that can pend, mask and clear
  localparam logic [31:0] EVENT_BITS = 32'h0000_7333;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic busy;
    logic contact_lost;
    logic pen_touch;
    logic overrun;
    logic conv_done;
    logic [11:0] result;
  } conv_in_s;

endpackage : conv_status_pkg

/* File: tb_top.sv */
// Testbench for the converter status and event flag block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import conv_status_pkg::*;
;
  logic pclk;
  logic presetn;
  apb_req_s req;
  apb_rsp_s rsp;
  conv_in_s cin;
  logic irq;
  int err_total;
  int cmp_count;
  logic [31:0] rd;
  logic [11:0] cmp_val [4] = '{12'h0ff, 12'h100, 12'h800, 12'h801};
  logic [31:0] cmp_exp [4] = '{32'h1101, 32'h4101, 32'h4101, 32'h2101};

  conv_status conv_status_inst (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .conv_in(cin), .irq(irq));
  conv_model conv_model_inst (.pclk(pclk), .conv_in(cin));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1)
    begin
      err_total++;
      finish_test();
    end
    rd = rsp.prdata;
    check("slave error", {31'h0, rsp.pslverr}, 32'h0);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task automatic chk_rd(input string name, input logic [7:0] a,
    input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : chk_rd
  task automatic chk_irq(input logic exp);
    @(posedge pclk);
    #1;
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : chk_irq

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    #1000000;
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    req = '0;
    err_total = 0;
    cmp_count = 0;
    rd = '0;
    conv_model_inst.idle();
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd("mask reset", OFF_IRQ_MASK, 32'h0);
    chk_rd("live idle", OFF_LIVE_STATUS, 32'h100);
    xfer(1'b1, OFF_EVENT_CLEAR, EVENT_BITS);
    chk_rd("pend empty", OFF_PENDING_EVENTS, 32'h0);
    xfer(1'b1, OFF_CONTROL, 32'h100);
    chk_rd("enable on", OFF_LIVE_STATUS, 32'h0100_0100);
    xfer(1'b1, OFF_CONTROL, 32'h200);
    chk_rd("enable off", OFF_LIVE_STATUS, 32'h100);
    xfer(1'b1, OFF_IRQ_ENABLE_SET, 32'h3);
    xfer(1'b1, OFF_IRQ_ENABLE_SET, 32'h10);
    chk_rd("mask set", OFF_IRQ_MASK, 32'h13);
    xfer(1'b1, OFF_IRQ_ENABLE_CLEAR, 32'h1);
    chk_rd("mask clear", OFF_IRQ_MASK, 32'h12);
    chk_rd("unmapped", 8'h3c, 32'h0);
    chk_irq(1'b0);
    conv_model_inst.seq(1'b1);
    chk_rd("live busy", OFF_LIVE_STATUS, 32'h200);
    chk_rd("pend busy", OFF_PENDING_EVENTS, 32'h200);
    conv_model_inst.ovr();
    conv_model_inst.done(12'h050);
    chk_rd("live ovr", OFF_LIVE_STATUS, 32'h203);
    chk_rd("pend ovr", OFF_PENDING_EVENTS, 32'h203);
    chk_irq(1'b1);
    chk_rd("result", OFF_LAST_RESULT, 32'h050);
    xfer(1'b1, OFF_EVENT_CLEAR, 32'h3);
    chk_irq(1'b0);
    conv_model_inst.done(12'h050);
    chk_rd("pend again", OFF_PENDING_EVENTS, 32'h201);
    conv_model_inst.seq(1'b0);
    conv_model_inst.seq(1'b1);
    chk_rd("ovr new seq", OFF_LIVE_STATUS, 32'h201);
    conv_model_inst.seq(1'b0);
    xfer(1'b1, OFF_THRESHOLD, 32'h0800_0100);
    chk_rd("threshold", OFF_THRESHOLD, 32'h0800_0100);
    xfer(1'b1, OFF_MODE, 32'h20);
    for (int i = 0; i < 4; i++)
    begin
      conv_model_inst.done(cmp_val[i]);
      chk_rd("compare", OFF_LIVE_STATUS, cmp_exp[i]);
    end
    xfer(1'b1, OFF_MODE, 32'h0);
    chk_rd("compare off", OFF_LIVE_STATUS, 32'h101);
    conv_model_inst.touch(1'b1, 1'b1);
    chk_rd("touch off", OFF_LIVE_STATUS, 32'h101);
    xfer(1'b1, OFF_MODE, 32'h10);
    chk_rd("touch on", OFF_LIVE_STATUS, 32'h131);
    chk_irq(1'b1);
    xfer(1'b1, OFF_EVENT_CLEAR, 32'h10);
    chk_irq(1'b0);
    xfer(1'b1, OFF_CONTROL, 32'h1);
    chk_rd("soft reset", OFF_LIVE_STATUS, 32'h100);
    chk_rd("mask zero", OFF_IRQ_MASK, 32'h0);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
